/* oscc_ctrl.sv */
// Purpose: clock source selection, switch sequencing, pll status, doze and divider settings
// Assumes: straps and analog status pins are asynchronous; irq_event is on mclk
// Notes: read data appear one cycle after the read strobe and only then
`default_nettype none

// Functional notes
// - active source field read-only; code 100 falls back to fast RC.
// - requested source field writable; loaded from power-on strap after reset.
// - switch request stays high while pending; device clears it when done.
// - freeze bit plus monitor strap blocks clock and pll setting writes.
// - pll status reads 1 when a pll source is active and locked or its start-up timer elapsed.
// - clock fail flag set by monitor, stays until software clears it.
// - software writing 1 to fail flag raises the failure trap.
// - oscillator control writes need a prior unlock key sequence.
// - with wake bit set, an interrupt clears doze enable.
// - doze ratio divides by 1 to 128; resets to divide by 8.
// - doze enable off forces processor to peripheral ratio 1:1.
// - doze ratio writes ignored while doze enable is set.
// - doze enable cannot be set while doze ratio is 000.
// - fast RC postscaler codes divide 1..64 then 256; resets to 000.
// - pll prescaler codes 0001..1000 divide by 1..8; resets to 0001.
// - prescaler writes accepted even while the pll runs.
// - feedback divider resets to 150; software uses 16 to 200.
// - reserved and unimplemented bits read as zero.
// - instruction clock is the system clock divided by two.
// - pll output follows feedback, prescaler and postscaler settings.
module oscc_ctrl
    import oscc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // straps and analog status pins
    input wire logic [2:0] poweron_source_cfg,
    input wire logic switch_monitor_cfg_bit,
    input wire logic pll_locked_in,
    input wire logic clock_fail_detect,
    // interrupt activity from the core
    input wire logic irq_event,
    // clock control outputs
    output logic [2:0] active_source_sel,
    output logic pll_enable,
    output logic osc_fail_trap,
    output logic instr_clk_en,
    output logic cpu_clk_en,
    output logic [2:0] fast_rc_postscale,
    output logic [3:0] loop_ref_prediv,
    output logic [7:0] loop_feedback_divider
);
    localparam int SW_MAX = SWITCH_SETTLE_CYC + 1;

    // true for either pll source
    function automatic logic is_pll(input logic [2:0] src);
        is_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    // reserved code runs from fast RC
    function automatic logic [2:0] fallback(input logic [2:0] src);
        fallback = (src == SRC_RSVD) ? SRC_FRC : src;
    endfunction

    // direct hop between the two pll sources
    function automatic logic pll_hop(input logic [2:0] from, input logic [2:0] to);
        pll_hop = is_pll(from) && is_pll(to) && (from != to);
    endfunction

    // low bits mask for a power of two doze ratio
    function automatic logic [6:0] doze_mask(input logic [2:0] code);
        doze_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    // synchronisers, not reset so the strap is valid at release
    logic [2:0] cfg_s1, cfg_s2;
    logic mon_s1, mon_s2, lock_s1, lock_s2, fail_s1, fail_s2, fail_prev_q;
    always_ff @(posedge mclk)
    begin
        cfg_s1 <= poweron_source_cfg;
        cfg_s2 <= cfg_s1;
        mon_s1 <= switch_monitor_cfg_bit;
        mon_s2 <= mon_s1;
        lock_s1 <= pll_locked_in;
        lock_s2 <= lock_s1;
        fail_s1 <= clock_fail_detect;
        fail_s2 <= fail_s1;
        fail_prev_q <= fail_s2;
    end

    // state
    oscc_state_e state_q, state_d;
    logic [SETTLE_W-1:0] settle_q, settle_d;
    logic [STARTUP_W-1:0] start_q, start_d;
    logic [2:0] active_q, active_d, req_src_q, req_src_d;
    logic switch_q, switch_d, freeze_q, freeze_d, fail_q, fail_d, trap_q, trap_d;
    logic lock_q, lock_d, pll_en_q, pll_en_d, cfg_pend_q, cfg_pend_d;
    logic wake_q, wake_d, cpu_slowdown_enable_q, cpu_slowdown_enable_d, instr_q, instr_d, cpu_en_q, cpu_en_d;
    logic [2:0] doze_q, doze_d, frcps_q, frcps_d;
    logic [3:0] prediv_q, prediv_d;
    logic [7:0] fbdiv_q, fbdiv_d;
    logic [6:0] doze_cnt_q, doze_cnt_d;
    logic [1:0] unlock_q, unlock_d;
    logic [15:0] rdata_q, rdata_d;
    logic frozen, osc_wr, osc_ok, div_wr, fbd_wr, hw_fail;

    // decoded strobes
    assign frozen = freeze_q && mon_s2;
    assign osc_wr = reg_wr && (reg_addr == ADDR_OSC_CTRL);
    assign osc_ok = osc_wr && (unlock_q == 2'h2);
    assign div_wr = reg_wr && (reg_addr == ADDR_CLK_DIV);
    assign fbd_wr = reg_wr && (reg_addr == ADDR_PLL_FBD);
    assign hw_fail = fail_s2 && !fail_prev_q;

    // next state for source, switch, fail, doze and divider logic
    always_comb
    begin
        state_d = state_q;
        settle_d = settle_q;
        active_d = active_q;
        req_src_d = req_src_q;
        switch_d = switch_q;
        freeze_d = freeze_q;
        fail_d = fail_q;
        trap_d = 1'b0;
        cfg_pend_d = 1'b0;
        wake_d = wake_q;
        doze_d = doze_q;
        cpu_slowdown_enable_d = cpu_slowdown_enable_q;
        frcps_d = frcps_q;
        prediv_d = prediv_q;
        fbdiv_d = fbdiv_q;
        unlock_d = unlock_q;
        if (reg_wr && (reg_addr == ADDR_UNLOCK))
        begin
            if (reg_wdata == UNLOCK_KEY1)
                unlock_d = 2'h1;
            else if ((reg_wdata == UNLOCK_KEY2) && (unlock_q == 2'h1))
                unlock_d = 2'h2;
            else
                unlock_d = 2'h0;
        end
        else if (osc_wr)
            unlock_d = 2'h0; // one write per unlock, locked or not
        // strap loads requested and active source once after reset
        if (cfg_pend_q)
        begin
            req_src_d = cfg_s2;
            active_d = fallback(cfg_s2);
        end
        // oscillator_control write, only once unlocked
        if (osc_ok)
        begin
            // freeze blocks source and switch changes
            if (!frozen)
            begin
                req_src_d = reg_wdata[OSC_REQ_LSB +: 3];
                freeze_d = reg_wdata[OSC_FREEZE_BIT];
                if (reg_wdata[OSC_SWITCH_BIT] && !switch_q)
                begin
                    switch_d = 1'b1;
                    settle_d = '0;
                    state_d = ST_SETTLE;
                end
            end
            // software set behaves like a real failure
            if (reg_wdata[OSC_FAIL_BIT])
                trap_d = 1'b1;
            fail_d = reg_wdata[OSC_FAIL_BIT];
        end
        // monitor sets the flag; set wins over a clear
        if (hw_fail)
        begin
            fail_d = 1'b1;
            trap_d = 1'b1;
        end
        // switch sequencer
        case (state_q)
            ST_IDLE:
            begin
            end
            ST_SETTLE:
            begin
                // forbidden hop abandons the switch; depends on it
                if (pll_hop(active_q, req_src_q))
                begin
                    switch_d = 1'b0;
                    state_d = ST_IDLE;
                end
                // commit source and clear request together
                else if (settle_q == SETTLE_W'(SWITCH_SETTLE_CYC - 1))
                begin
                    active_d = fallback(req_src_q);
                    switch_d = 1'b0;
                    state_d = ST_IDLE;
                end
                else
                    settle_d = settle_q + 1'b1;
            end
            default:
            begin
                switch_d = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
        // clock_divider write, no unlock needed
        if (div_wr)
        begin
            wake_d = reg_wdata[DIV_WAKE_BIT];
            // ratio held while doze is on
            if (!cpu_slowdown_enable_q)
                doze_d = reg_wdata[DIV_DOZE_LSB +: 3];
            // doze cannot start with ratio 000
            cpu_slowdown_enable_d = reg_wdata[DIV_CPU_SLOWDOWN_ENABLE_BIT] && (doze_d != 3'h0);
            // dividers take effect even with the pll running
            if (!frozen)
            begin
                frcps_d = reg_wdata[DIV_FRCPS_LSB +: 3];
                prediv_d = reg_wdata[DIV_PRE_LSB +: 4];
            end
        end
        // feedback divider, range left to software
        if (fbd_wr && !frozen)
            fbdiv_d = reg_wdata[7:0];
        // interrupt restores full speed, wins over a write
        if (wake_q && irq_event)
            cpu_slowdown_enable_d = 1'b0;
    end

    // pll start-up timer and lock status
    always_comb
    begin
        pll_en_d = is_pll(active_d);
        start_d = start_q;
        lock_d = 1'b0;
        if (is_pll(active_q))
        begin
            if (start_q != STARTUP_W'(PLL_STARTUP_CYC))
                start_d = start_q + 1'b1;
            lock_d = lock_s2 || (start_q == STARTUP_W'(PLL_STARTUP_CYC));
        end
        else
            start_d = '0;
    end

    // clock enables and read data
    always_comb
    begin
        // instruction clock at half the system clock
        instr_d = !instr_q;
        doze_cnt_d = doze_cnt_q + 1'b1;
        // processor runs one cycle in 2^ratio, or every cycle
        cpu_en_d = !cpu_slowdown_enable_q || ((doze_cnt_q & doze_mask(doze_q)) == 7'h00);
        rdata_d = 16'h0000;
        // unused and reserved bits read zero
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_OSC_CTRL:
                    rdata_d = {1'b0, active_q, 1'b0, req_src_q, freeze_q, 1'b0,
                               lock_q, 1'b0, fail_q, 2'b00, switch_q};
                ADDR_CLK_DIV:
                    rdata_d = {wake_q, doze_q, cpu_slowdown_enable_q, frcps_q, 4'h0, prediv_q};
                ADDR_PLL_FBD:
                    rdata_d = {8'h00, fbdiv_q};
                default:
                    rdata_d = 16'h0000;
            endcase
        end
    end

    // registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            settle_q <= '0;
            start_q <= '0;
            active_q <= SRC_FRC;
            req_src_q <= SRC_FRC;
            switch_q <= 1'b0;
            freeze_q <= 1'b0;
            fail_q <= 1'b0;
            trap_q <= 1'b0;
            lock_q <= 1'b0;
            pll_en_q <= 1'b0;
            cfg_pend_q <= 1'b1;
            wake_q <= 1'b0;
            cpu_slowdown_enable_q <= 1'b0;
            doze_q <= DOZE_RST;
            frcps_q <= FRCPS_RST;
            prediv_q <= PREDIV_RST;
            fbdiv_q <= FBDIV_RST;
            doze_cnt_q <= '0;
            unlock_q <= 2'h0;
            instr_q <= 1'b0;
            cpu_en_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            settle_q <= settle_d;
            start_q <= start_d;
            active_q <= active_d;
            req_src_q <= req_src_d;
            switch_q <= switch_d;
            freeze_q <= freeze_d;
            fail_q <= fail_d;
            trap_q <= trap_d;
            lock_q <= lock_d;
            pll_en_q <= pll_en_d;
            cfg_pend_q <= cfg_pend_d;
            wake_q <= wake_d;
            cpu_slowdown_enable_q <= cpu_slowdown_enable_d;
            doze_q <= doze_d;
            frcps_q <= frcps_d;
            prediv_q <= prediv_d;
            fbdiv_q <= fbdiv_d;
            doze_cnt_q <= doze_cnt_d;
            unlock_q <= unlock_d;
            instr_q <= instr_d;
            cpu_en_q <= cpu_en_d;
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata = rdata_q;
    assign active_source_sel = active_q;
    assign pll_enable = pll_en_q;
    assign osc_fail_trap = trap_q;
    assign instr_clk_en = instr_q;
    assign cpu_clk_en = cpu_en_q;
    assign fast_rc_postscale = frcps_q;
    // analog pll multiplies by feedback over prescaler and postscalers
    assign loop_ref_prediv = prediv_q;
    assign loop_feedback_divider = fbdiv_q;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_switch_commit: assert property (
        (state_q == ST_SETTLE) && !pll_hop(active_q, req_src_q)
        && (settle_q == SETTLE_W'(SWITCH_SETTLE_CYC - 1))
        |=> !switch_q && (active_q == fallback($past(req_src_q))))
        else $error("switch did not commit source with request clear");
    a_pll_hop_block: assert property (
        (state_q == ST_SETTLE) && pll_hop(active_q, req_src_q)
        |=> !switch_q && $stable(active_q))
        else $error("pll hop was not abandoned");
    a_switch_bound: assert property (
        $rose(switch_q) |-> ##[1:SW_MAX] !switch_q)
        else $error("switch request did not clear in time");
    a_lock_off: assert property (
        !is_pll(active_q) |=> !lock_q)
        else $error("lock status high with pll unused");
    a_fail_sticky: assert property (
        fail_q && !osc_ok |=> fail_q)
        else $error("fail flag dropped without software clear");
    a_fail_trap: assert property (
        osc_ok && reg_wdata[OSC_FAIL_BIT] |=> osc_fail_trap && fail_q)
        else $error("software fail set gave no trap");
    a_write_locked: assert property (
        osc_wr && (unlock_q != 2'h2) && !cfg_pend_q |=> $stable(req_src_q))
        else $error("locked write changed requested source");
    a_doze_hold: assert property (
        cpu_slowdown_enable_q && div_wr |=> $stable(doze_q))
        else $error("doze ratio changed while doze enabled");
    a_cpu_slowdown_enable_zero: assert property (
        (doze_q == 3'h0) |-> !cpu_slowdown_enable_q)
        else $error("doze enabled with ratio zero");
    a_wake_clear: assert property (
        wake_q && irq_event |=> !cpu_slowdown_enable_q)
        else $error("interrupt did not clear doze enable");
    a_freeze_fbd: assert property (
        frozen && fbd_wr |=> $stable(fbdiv_q))
        else $error("frozen feedback divider was written");
    a_ratio_full: assert property (
        !cpu_slowdown_enable_q && !cfg_pend_q |=> cpu_clk_en) // enable flop still in reset at release
        else $error("processor clock slowed with doze off");

    c_switch_done: cover property ($fell(switch_q) && $changed(active_q));
    c_switch_abandon: cover property ((state_q == ST_SETTLE) && pll_hop(active_q, req_src_q));
    c_doze_wake: cover property (cpu_slowdown_enable_q && wake_q && irq_event);
endmodule
`default_nettype wire

/* oscc_pkg.sv */
// Purpose: shared constants for the oscillator select, doze and pll divider control
// Assumes: mclk is the system clock at 200 MHz
// Notes: register indices are word indices on the plain register port
`default_nettype none
package oscc_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SWITCH_SETTLE_NS = 50;
    localparam int SWITCH_SETTLE_CYC = (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_STARTUP_NS = 1000;
    localparam int PLL_STARTUP_CYC = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;
    localparam int STARTUP_W = 9;

    // register indices
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLK_DIV = 4'h1;
    localparam logic [3:0] ADDR_PLL_FBD = 4'h2;
    localparam logic [3:0] ADDR_UNLOCK = 4'h3;
    localparam logic [15:0] UNLOCK_KEY1 = 16'h0055;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h00AA;

    // oscillator_control field positions
    localparam int OSC_ACTIVE_LSB = 12;
    localparam int OSC_REQ_LSB = 8;
    localparam int OSC_FREEZE_BIT = 7;
    localparam int OSC_LOCK_BIT = 5;
    localparam int OSC_FAIL_BIT = 3;
    localparam int OSC_SWITCH_BIT = 0;

    // clock_divider field positions
    localparam int DIV_WAKE_BIT = 15;
    localparam int DIV_DOZE_LSB = 12;
    localparam int DIV_CPU_SLOWDOWN_ENABLE_BIT = 11;
    localparam int DIV_FRCPS_LSB = 8;
    localparam int DIV_PRE_LSB = 0;

    // reset values
    localparam logic [2:0] DOZE_RST = 3'h3;
    localparam logic [2:0] FRCPS_RST = 3'h0;
    localparam logic [3:0] PREDIV_RST = 4'h1;
    localparam logic [7:0] FBDIV_RST = 8'h96;

    // source encodings
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_RSVD = 3'h4;

    // source switch sequencer
    typedef enum logic [0:0] {ST_IDLE, ST_SETTLE} oscc_state_e;
endpackage
`default_nettype wire

/* oscc_ctrl_tb.sv */
// Purpose: self-checking bench for oscc_ctrl registers, source switching, doze and dividers
// Assumes: straps and the pll lock input change only where a test says so
// Notes: every access task is entered just after a rising edge of mclk
`default_nettype none
module oscc_ctrl_tb
    import oscc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset_n, reg_wr, reg_rd, monitor_cfg, fail_det, irq, lock_in;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [2:0] strap, active_source_sel, fast_rc_postscale;
    logic pll_enable, osc_fail_trap, instr_clk_en, cpu_clk_en;
    logic [3:0] loop_ref_prediv;
    logic [7:0] loop_feedback_divider;
    int err_total = 0, comparisons = 0, cycles = 0, traps = 0;
    logic [2:0] req_tab [8] = '{3'h1, 3'h0, 3'h2, 3'h5, 3'h4, 3'h7, 3'h6, 3'h0};
    logic [2:0] exp_tab [8] = '{3'h1, 3'h0, 3'h2, 3'h5, 3'h0, 3'h7, 3'h6, 3'h0};

    // device under test; lock input mostly low so the start-up timer sets lock
    oscc_ctrl i_oscc_ctrl (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .poweron_source_cfg(strap), .switch_monitor_cfg_bit(monitor_cfg),
        .pll_locked_in(lock_in), .clock_fail_detect(fail_det), .irq_event(irq),
        .active_source_sel(active_source_sel), .pll_enable(pll_enable),
        .osc_fail_trap(osc_fail_trap), .instr_clk_en(instr_clk_en), .cpu_clk_en(cpu_clk_en),
        .fast_rc_postscale(fast_rc_postscale), .loop_ref_prediv(loop_ref_prediv),
        .loop_feedback_divider(loop_feedback_divider)
    );

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // timeout and trap pulse counter; trap is a one-cycle pulse so count it here
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (osc_fail_trap === 1'b1) traps <= traps + 1;
        if (cycles == 8000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single write with one idle cycle after, so the strobe is never set twice in a step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // both keys then the control write, strobe held high across all three
    task automatic unlock_wr(input logic [15:0] d);
        reg_addr <= ADDR_UNLOCK;
        reg_wdata <= UNLOCK_KEY1;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wdata <= UNLOCK_KEY2;
        @(posedge mclk);
        reg_addr <= ADDR_OSC_CTRL;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask

    task automatic switch_to(input logic [2:0] req, input logic [2:0] exp);
        int n;
        n = 0;
        unlock_wr({5'h0, req, 8'h01});
        while (active_source_sel !== exp && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        repeat (12) @(posedge mclk);
        rd(ADDR_OSC_CTRL, v);
        chk("active", {13'h0, v[14:12]}, {13'h0, exp});
        chk("switch bit", {15'h0, v[0]}, 16'h0000);
    endtask

    task automatic cpu_count(input int n, input int exp);
        int k;
        k = 0;
        repeat (n)
        begin
            @(posedge mclk);
            #1 if (cpu_clk_en === 1'b1) k++;
        end
        chk("cpu enables", 16'(k), 16'(exp));
    endtask

    initial
    begin
        {reg_wr, reg_rd, monitor_cfg, fail_det, irq, lock_in} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        strap = 3'h2;
        reset_n = 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ADDR_OSC_CTRL, v);
        chk("osc reset", v, 16'h2200);
        rd(ADDR_CLK_DIV, v);
        chk("div reset", v, 16'h3001);
        rd(ADDR_PLL_FBD, v);
        chk("fbd reset", v, 16'h0096);
        rd(4'h9, v);
        chk("unmapped", v, 16'h0000);
        chk("fbd out", {8'h0, loop_feedback_divider}, 16'h0096);
        wr(ADDR_OSC_CTRL, 16'h0301);
        rd(ADDR_OSC_CTRL, v);
        chk("no unlock", v, 16'h2200);
        $display("test reset and unlock done");
        switch_to(3'h3, 3'h3);
        chk("pll enable", {15'h0, pll_enable}, 16'h0001);
        chk("lock early", {15'h0, v[5]}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CLK_DIV, {4'h3, 1'b0, 3'(i), 4'h0, 4'(i + 1)});
            chk("postscale", {13'h0, fast_rc_postscale}, 16'(i));
            chk("prediv", {12'h0, loop_ref_prediv}, 16'(i + 1));
        end
        // sample off the edge so the flop has settled
        #1 v[0] = instr_clk_en;
        @(posedge mclk);
        #1 chk("instr toggle", {15'h0, instr_clk_en}, {15'h0, ~v[0]});
        @(posedge mclk);
        #1 chk("instr phase", {15'h0, instr_clk_en}, {15'h0, v[0]});
        repeat (200) @(posedge mclk);
        rd(ADDR_OSC_CTRL, v);
        chk("lock late", {15'h0, v[5]}, 16'h0001);
        switch_to(3'h1, 3'h3);
        switch_to(3'h0, 3'h0);
        chk("lock off", {15'h0, v[5]}, 16'h0000);
        for (int i = 0; i < 8; i++) switch_to(req_tab[i], exp_tab[i]);
        // analog lock reported before the timer, but never with the pll unused
        lock_in <= 1'b1;
        switch_to(3'h1, 3'h1);
        chk("lock input", {15'h0, v[5]}, 16'h0001);
        switch_to(3'h0, 3'h0);
        chk("lock disabled", {15'h0, v[5]}, 16'h0000);
        lock_in <= 1'b0;
        $display("test switching done");
        unlock_wr(16'h0080);
        wr(ADDR_PLL_FBD, 16'h0020);
        rd(ADDR_PLL_FBD, v);
        chk("unfrozen", v, 16'h0020);
        monitor_cfg <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(ADDR_PLL_FBD, 16'h00C8);
        rd(ADDR_PLL_FBD, v);
        chk("frozen fbd", v, 16'h0020);
        unlock_wr(16'h0781);
        repeat (20) @(posedge mclk);
        chk("frozen src", {13'h0, active_source_sel}, 16'h0000);
        monitor_cfg <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(ADDR_PLL_FBD, 16'h00C8);
        rd(ADDR_PLL_FBD, v);
        chk("fbd max", v, 16'h00C8);
        unlock_wr(16'h0000);
        $display("test freeze done");
        fail_det <= 1'b1;
        repeat (8) @(posedge mclk);
        fail_det <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("hw traps", 16'(traps), 16'h0001);
        rd(ADDR_OSC_CTRL, v);
        chk("fail set", {15'h0, v[3]}, 16'h0001);
        unlock_wr(16'h0000);
        rd(ADDR_OSC_CTRL, v);
        chk("fail clear", {15'h0, v[3]}, 16'h0000);
        unlock_wr(16'h0008);
        repeat (3) @(posedge mclk);
        chk("sw traps", 16'(traps), 16'h0002);
        rd(ADDR_OSC_CTRL, v);
        chk("sw fail", {15'h0, v[3]}, 16'h0001);
        unlock_wr(16'h0000);
        $display("test clock fail done");
        wr(ADDR_CLK_DIV, 16'h0801);
        rd(ADDR_CLK_DIV, v);
        chk("doze zero", v, 16'h0001);
        wr(ADDR_CLK_DIV, 16'h2801);
        cpu_count(16, 4);
        wr(ADDR_CLK_DIV, 16'h7801);
        rd(ADDR_CLK_DIV, v);
        chk("doze held", v, 16'h2801);
        wr(ADDR_CLK_DIV, 16'h2001);
        cpu_count(16, 16);
        wr(ADDR_CLK_DIV, 16'hF801);
        cpu_count(256, 2);
        irq <= 1'b1;
        @(posedge mclk);
        irq <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CLK_DIV, v);
        chk("wake clears", v, 16'hF001);
        wr(ADDR_CLK_DIV, 16'h7801);
        irq <= 1'b1;
        @(posedge mclk);
        irq <= 1'b0;
        @(posedge mclk);
        rd(ADDR_CLK_DIV, v);
        chk("wake off", v, 16'h7801);
        $display("test doze done");
        // second reset with the reserved strap code
        strap <= 3'h4;
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ADDR_OSC_CTRL, v);
        chk("strap reserved", v, 16'h0400);
        rd(ADDR_CLK_DIV, v);
        chk("div after reset", v, 16'h3001);
        $display("test strap reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
